// >>> dv/isp_port_tb.sv
/*
  Self-checking bench for isp_port: programmer model on the link, memory model on the controller side,
  reference model of arrays and busy time. Assumes shortened self-timed waits.
*/
`timescale 1ns/1ps
module isp_port_tb;
  import isp_pkg::*;
  // ==========================================================
  // Signals and models
  // ==========================================================
  localparam int FW = 400; // Flash page wait
  localparam int EW = 600; // EEPROM byte wait
  localparam int XW = 800; // Erase wait
  logic clk, rst_n, reset_pin_n, sck, mosi, miso, nvm_hi, operation_pending_flag;
  logic nvm_pbuf_we, nvm_page_we, nvm_ee_we, nvm_erase, nvm_rd_flash, nvm_rd_ee;
  logic [15:0] nvm_addr;
  logic [7:0] nvm_wdata, nvm_rd_data;
  logic [7:0] mflash [0:131071], mee [0:4095], mpbuf [0:255]; // Memory model
  logic [7:0] rflash [0:131071], ree [0:4095], rpbuf [0:255]; // Reference model
  int bad_count = 0, check_count = 0, cyc = 0, strobes = 0, busy_end = 0, busy_pg = 0;
  pend_e busy_kind = PEND_NONE;
  logic synced = 1'b0;

  isp_port #(.FLASH_WAIT_CYC(FW), .EEPROM_WAIT_CYC(EW), .ERASE_CYC(XW)) dut_u (.clk(clk), .rst_n(rst_n),
    .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi), .miso(miso), .nvm_addr(nvm_addr), .nvm_hi(nvm_hi),
    .nvm_wdata(nvm_wdata), .nvm_pbuf_we(nvm_pbuf_we), .nvm_page_we(nvm_page_we), .nvm_ee_we(nvm_ee_we),
    .nvm_erase(nvm_erase), .nvm_rd_flash(nvm_rd_flash), .nvm_rd_ee(nvm_rd_ee), .nvm_rd_data(nvm_rd_data),
    .operation_pending_flag(operation_pending_flag));
  isp_programmer prog_u (.clk(clk), .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi), .miso(miso));

  // Clock, cycle count and strobe count
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    strobes <= strobes + int'(nvm_pbuf_we) + int'(nvm_page_we) + int'(nvm_ee_we) + int'(nvm_erase)
      + int'(nvm_rd_flash) + int'(nvm_rd_ee);
  end

  // Memory controller: data stands through the cycle after a read pulse, noise otherwise
  logic [7:0] mem_q = 8'h00; // Word fetched at the read pulse
  logic mem_v = 1'b0; // Fetched word goes out next
  always @(negedge clk) begin : mem_model
    nvm_rd_data <= mem_v ? mem_q : 8'($urandom);
    mem_v = nvm_rd_flash | nvm_rd_ee;
    if (nvm_rd_flash) mem_q = mflash[{nvm_addr, nvm_hi}];
    else if (nvm_rd_ee) mem_q = mee[nvm_addr[11:0]];
    if (nvm_pbuf_we) mpbuf[{nvm_addr[6:0], nvm_hi}] = nvm_wdata;
    if (nvm_ee_we) mee[nvm_addr[11:0]] = nvm_wdata;
    if (nvm_page_we) for (int k = 0; k < 256; k++) mflash[{nvm_addr[15:7], 8'(k)}] = mpbuf[k];
    if (nvm_erase) for (int k = 0; k < 131072; k++) mflash[k] = 8'hff;
    if (nvm_erase) for (int k = 0; k < 4096; k++) mee[k] = 8'hff;
  end

  // ==========================================================
  // Checking and reference model
  // ==========================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Send one instruction and compare the pending flag, the byte one and two echoes, read data and poll flag with the reference model
  task automatic op(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] b4);
    logic [31:0] r;
    logic bz, br, was, acc;
    int s, n0, fi, ei, pg;
    s = cyc;
    n0 = strobes;
    was = synced;
    fi = {b2, b3, b1[3]};
    ei = {b2[3:0], b3};
    pg = {b2, b3[7]};
    bz = (s + 192 < busy_end);
    br = (s + 194 < busy_end);
    acc = was && (s + 256 >= busy_end);
    prog_u.xfer({b1, b2, b3, b4}, r);
    chk({7'h00, operation_pending_flag}, {7'h00, cyc <= busy_end});
    if (!was) begin
      repeat (3) @(negedge clk); // Let a late strobe reach the count
      chk(8'(strobes - n0), 8'h00);
    end
    if (was) chk(r[23:16], b1);
    if ({b1, b2} == {OP_ENABLE_1, OP_ENABLE_2}) begin
      synced = 1'b1;
      chk(r[15:8], OP_ENABLE_2);
    end else if (was) begin
      chk(r[15:8], b2);
      case (b1 & H_MASK)
        OP_RD_FLASH: chk(r[7:0], (br && (busy_kind == PEND_ERASE || (busy_kind == PEND_FLASH
          && fi / 256 == busy_pg))) ? BLANK_BYTE : rflash[fi]);
        OP_RD_EE: chk(r[7:0], (br && (busy_kind == PEND_ERASE || (busy_kind == PEND_EEPROM
          && ei == busy_pg))) ? BLANK_BYTE : ree[ei]);
        OP_POLL: chk(r[7:0], {7'h00, bz});
        OP_LD_PAGE: rpbuf[{b3[6:0], b1[3]}] = b4;
        default: ;
      endcase
      if (acc && b1 == OP_WR_PAGE) begin
        busy_kind = PEND_FLASH;
        busy_end = s + 258 + FW;
        busy_pg = pg;
        for (int k = 0; k < 256; k++) rflash[pg * 256 + k] = rpbuf[k];
      end else if (acc && b1 == OP_WR_EE) begin
        busy_kind = PEND_EEPROM;
        busy_end = s + 258 + EW;
        busy_pg = ei;
        ree[ei] = b4;
      end else if (acc && b1 == OP_ENABLE_1 && b2[7:5] == OP_ERASE_2) begin
        busy_kind = PEND_ERASE;
        busy_end = s + 258 + XW;
        for (int k = 0; k < 131072; k++) rflash[k] = 8'hff;
        for (int k = 0; k < 4096; k++) ree[k] = 8'hff;
      end
    end
  endtask : op

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // Watchdog: the sequence takes about 8090 cycles
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin : main
    logic [7:0] d, e2, e3, idx;
    logic [8:0] pg;
    rst_n = 1'b0;
    nvm_rd_data = 8'h00;
    for (int k = 0; k < 131072; k++) mflash[k] = 8'(k * 37 + 11);
    for (int k = 0; k < 131072; k++) rflash[k] = 8'(k * 37 + 11);
    for (int k = 0; k < 4096; k++) mee[k] = 8'(k * 13 + 5);
    for (int k = 0; k < 4096; k++) ree[k] = 8'(k * 13 + 5);
    for (int k = 0; k < 256; k++) mpbuf[k] = 8'hff;
    for (int k = 0; k < 256; k++) rpbuf[k] = 8'hff;
    void'($urandom(32'h2804b39e));
    e2 = 8'($urandom) & 8'h0f;
    e3 = 8'($urandom);
    pg = 9'($urandom);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    prog_u.enter();
    op(OP_RD_FLASH, 8'h01, 8'h02, 8'h00);
    op(OP_ENABLE_1, OP_ENABLE_2, 8'($urandom), 8'($urandom));
    op(OP_RD_FLASH | 8'h08, 8'($urandom), 8'($urandom), 8'($urandom));
    op(OP_RD_EE, e2, e3, 8'($urandom));
    op(OP_ENABLE_1, 8'h80 | (8'($urandom) & 8'h1f), 8'($urandom), 8'($urandom));
    op(OP_WR_EE, e2, e3, 8'h3c);
    op(OP_POLL, 8'h00, 8'($urandom), 8'($urandom));
    op(OP_POLL, 8'h00, 8'($urandom), 8'($urandom));
    op(OP_RD_EE, e2, e3, 8'($urandom));
    idx = 8'h00;
    for (int j = 0; j < 4; j++) begin
      idx = 8'($urandom) & 8'h7f;
      op(OP_LD_PAGE, 8'h00, idx, 8'($urandom));
      op(OP_LD_PAGE | 8'h08, 8'h00, idx, 8'($urandom));
    end
    op(OP_WR_PAGE, pg[8:1], {pg[0], 7'($urandom)}, 8'($urandom));
    op(OP_RD_FLASH, pg[8:1], {pg[0], idx[6:0]}, 8'($urandom));
    op(OP_RD_FLASH, pg[8:1], {pg[0], idx[6:0]}, 8'($urandom));
    op(OP_RD_FLASH | 8'h08, pg[8:1], {pg[0], idx[6:0]}, 8'($urandom));
    op(OP_RD_FLASH, pg[8:1] ^ 8'h01, {pg[0], idx[6:0]}, 8'($urandom));
    d = 8'($urandom) & 8'hfe;
    op(OP_WR_EE, e2, e3, d);
    op(OP_RD_EE, e2, e3, 8'($urandom));
    op(OP_POLL, 8'h00, 8'($urandom), 8'($urandom));
    op(OP_RD_EE, e2, e3, 8'($urandom));
    op(OP_POLL, 8'h00, 8'($urandom), 8'($urandom));
    op(OP_ENABLE_1, OP_ENABLE_2, 8'($urandom), 8'($urandom));
    prog_u.leave();
    synced = 1'b0;
    repeat (8) @(negedge clk);
    chk({7'h00, miso}, 8'h00);
    prog_u.enter();
    op(OP_WR_EE, e2, e3, 8'h01);
    op(OP_ENABLE_1, OP_ENABLE_2, 8'h00, 8'h00);
    op(OP_RD_EE, e2, e3, 8'($urandom));
    close_out();
  end
endmodule : isp_port_tb

// >>> dv/isp_programmer.sv
/*
  Programmer model for the serial programming port: drives the reset pin, SCK and MOSI, reads MISO.
  Assumes SCK half period of HALF_CYC clk cycles (800 ns period at 10 MHz); inputs move at falling clk.
*/
`timescale 1ns/1ps
module isp_programmer #(
  parameter int unsigned POWERUP_CYC = 50, // Shortened power-up wait
  parameter int unsigned HALF_CYC = 4 // SCK half period in clk cycles
) (
  // Clock
  input wire logic clk,
  // Serial link pins
  output logic reset_pin_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // ==========================================================
  // Idle state: out of programming, SCK low
  // ==========================================================
  initial begin
    reset_pin_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end

  // Pull reset low with SCK low, then wait before the first instruction
  task automatic enter();
    @(negedge clk);
    sck = 1'b0;
    reset_pin_n = 1'b0;
    repeat (POWERUP_CYC) @(negedge clk);
  endtask : enter

  // Release reset to leave programming mode
  task automatic leave();
    @(negedge clk);
    reset_pin_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : leave

  // One whole instruction, MSB first; MISO read late in each bit so sync delay is covered
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    @(negedge clk);
    for (int i = 31; i >= 0; i--) begin
      sck = 1'b0;
      mosi = tx[i];
      repeat (HALF_CYC) @(negedge clk);
      sck = 1'b1;
      repeat (HALF_CYC) @(negedge clk);
      rx = {rx[30:0], miso};
    end
    sck = 1'b0; // SCK stands low between frames
    mosi = ~tx[0]; // Stale data line does not hold its last value
  endtask : xfer
endmodule : isp_programmer

// >>> shared/isp_pkg.sv
/*
  Constants, opcodes and timing counts for the serial in-system programming port.
  Assumes a 10 MHz system clock; wait counts are derived from it.
*/
package isp_pkg;

  // ==========================================================
  // Clock and self-timed waits
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 100;           // System clock period
  localparam int unsigned FLASH_PAGE_WAIT_NS = 4500000;  // Flash page programming time
  localparam int unsigned EEPROM_BYTE_WAIT_NS = 9000000; // EEPROM byte programming time
  localparam int unsigned ERASE_WAIT_NS = 9000000;       // Chip erase time
  localparam int unsigned FLASH_PAGE_WAIT_CYC = (FLASH_PAGE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EEPROM_BYTE_WAIT_CYC = (EEPROM_BYTE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ERASE_WAIT_CYC = (ERASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAIT_W = 17;                   // Width of the busy counter

  // ==========================================================
  // Instruction framing
  // ==========================================================
  localparam logic [4:0] CNT_SYNCED = 5'h10;    // Bit count right after the enable word
  localparam logic [4:0] CNT_BYTE3_LAST = 5'h17; // Count before the last bit of byte three
  localparam logic [4:0] CNT_BYTE4_FIRST = 5'h18; // Count at the start of byte four
  localparam logic [4:0] CNT_LAST = 5'h1f;       // Count before the last bit of an instruction
  localparam int unsigned H_BIT = 3;             // High/low byte select in byte one

  // ==========================================================
  // Opcodes
  // ==========================================================
  localparam logic [7:0] OP_ENABLE_1 = 8'hac;   // Enable and erase, byte one
  localparam logic [7:0] OP_ENABLE_2 = 8'h53;   // Enable, byte two
  localparam logic [2:0] OP_ERASE_2 = 3'h4;     // Erase, top three bits of byte two
  localparam logic [7:0] H_MASK = 8'hf7;        // Clears the H bit before compare
  localparam logic [7:0] OP_RD_FLASH = 8'h20;   // Read program memory
  localparam logic [7:0] OP_LD_PAGE = 8'h40;    // Load page buffer
  localparam logic [7:0] OP_WR_PAGE = 8'h4c;    // Write page
  localparam logic [7:0] OP_RD_EE = 8'ha0;      // Read EEPROM
  localparam logic [7:0] OP_WR_EE = 8'hc0;      // Write EEPROM byte
  localparam logic [7:0] OP_POLL = 8'hf0;       // Poll busy flag
  localparam logic [7:0] BLANK_BYTE = 8'hff;    // Value read from a location being written

  // Pending self-timed operation
  typedef enum {PEND_NONE, PEND_FLASH, PEND_EEPROM, PEND_ERASE} pend_e;

endpackage : isp_pkg

// >>> src/isp_port.sv
/*
  Serial in-system programming port: framing, decode, self-timed busy and read-back.
  Assumes a memory controller that takes the strobes and answers reads one cycle later.
*/
`timescale 1ns/1ps
module isp_port import isp_pkg::*; #(
  parameter int unsigned FLASH_WAIT_CYC = FLASH_PAGE_WAIT_CYC, // Page programming cycles
  parameter int unsigned EEPROM_WAIT_CYC = EEPROM_BYTE_WAIT_CYC, // EEPROM byte cycles
  parameter int unsigned ERASE_CYC = ERASE_WAIT_CYC // Chip erase cycles
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link pins
  input wire logic reset_pin_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Memory controller side
  output logic [15:0] nvm_addr,
  output logic nvm_hi,
  output logic [7:0] nvm_wdata,
  output logic nvm_pbuf_we,
  output logic nvm_page_we,
  output logic nvm_ee_we,
  output logic nvm_erase,
  output logic nvm_rd_flash,
  output logic nvm_rd_ee,
  input wire logic [7:0] nvm_rd_data,
  // Status
  output logic operation_pending_flag
);

  // ==========================================================
  // Pin synchronisers and edge detect
  // ==========================================================
  logic sck_s;    // Filtered SCK
  logic mosi_s;   // Filtered MOSI
  logic rstpin_s; // Filtered chip reset pin
  logic sck_q;    // SCK one cycle back
  logic isp_active; // Programming mode allowed while the pin is low
  logic rise;     // SCK rising edge
  logic fall;     // SCK falling edge

  sync3 #(.INIT(1'b0)) u_sync_sck (.clk(clk), .rst_n(rst_n), .async_in(sck), .stable(sck_s));
  sync3 #(.INIT(1'b0)) u_sync_mosi (.clk(clk), .rst_n(rst_n), .async_in(mosi), .stable(mosi_s));
  sync3 #(.INIT(1'b1)) u_sync_rst (.clk(clk), .rst_n(rst_n), .async_in(reset_pin_n), .stable(rstpin_s));

  // Previous SCK level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck_s;
    end
  end

  assign isp_active = ~rstpin_s;
  assign rise = isp_active & sck_s & ~sck_q;
  assign fall = isp_active & ~sck_s & sck_q;

  // ==========================================================
  // Receive shift register and framing
  // ==========================================================
  logic [31:0] sr;       // Received bits, newest in bit 0
  logic [4:0] cnt;       // Bit position within the instruction
  logic enabled;         // Byte synchronisation reached
  logic [31:0] next_sr;  // Shift register after this rise
  logic [7:0] b1_24;     // Byte one seen at the end of byte three
  logic [7:0] b1_32;     // Byte one seen at the end of byte four
  logic [7:0] b2_32;     // Byte two at the end of byte four
  logic [7:0] b3_32;     // Byte three at the end of byte four
  logic [7:0] b4_32;     // Byte four at the end of byte four
  logic done24;          // Third byte complete
  logic done32;          // Whole instruction complete

  assign next_sr = {sr[30:0], mosi_s};
  assign b1_24 = next_sr[23:16];
  assign b1_32 = next_sr[31:24];
  assign b2_32 = next_sr[23:16];
  assign b3_32 = next_sr[15:8];
  assign b4_32 = next_sr[7:0];
  assign done24 = rise & enabled & (cnt == CNT_BYTE3_LAST);
  assign done32 = rise & enabled & (cnt == CNT_LAST);

  // Shift, count and hunt for the enable word bit by bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sr <= 32'h0;
      cnt <= 5'h0;
      enabled <= 1'b0;
    end else if (!isp_active) begin
      sr <= 32'h0; // Stale bits must not complete a false enable word
      cnt <= 5'h0;
      enabled <= 1'b0;
    end else if (rise) begin
      sr <= next_sr;
      if (!enabled && next_sr[15:0] == {OP_ENABLE_1, OP_ENABLE_2}) begin
        enabled <= 1'b1;
        cnt <= CNT_SYNCED;
      end else begin
        cnt <= cnt + 5'h1;
      end
    end
  end

  // ==========================================================
  // Self-timed busy state
  // ==========================================================
  pend_e pend;                 // Operation in progress
  logic [WAIT_W-1:0] wait_cnt; // Cycles left
  logic [15:0] busy_addr;      // Address being programmed
  logic busy;                  // Any operation in progress

  assign busy = (pend != PEND_NONE);
  assign operation_pending_flag = busy;

  // Start on a write strobe, count down, then return idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend <= PEND_NONE;
      wait_cnt <= '0;
      busy_addr <= 16'h0;
    end else begin
      case (pend)
        PEND_NONE: begin
          busy_addr <= nvm_addr;
          if (nvm_page_we) begin
            pend <= PEND_FLASH;
            wait_cnt <= WAIT_W'(FLASH_WAIT_CYC - 1);
          end else if (nvm_ee_we) begin
            pend <= PEND_EEPROM;
            wait_cnt <= WAIT_W'(EEPROM_WAIT_CYC - 1);
          end else if (nvm_erase) begin
            pend <= PEND_ERASE;
            wait_cnt <= WAIT_W'(ERASE_CYC - 1);
          end
        end
        default: begin
          if (wait_cnt == '0) begin
            pend <= PEND_NONE;
          end else begin
            wait_cnt <= wait_cnt - WAIT_W'(1);
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Instruction decode and memory strobes
  // ==========================================================
  // Strobes are one-cycle pulses; page, EEPROM and erase writes are dropped while busy, page loads are not
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nvm_addr <= 16'h0;
      nvm_hi <= 1'b0;
      nvm_wdata <= 8'h0;
      nvm_pbuf_we <= 1'b0;
      nvm_page_we <= 1'b0;
      nvm_ee_we <= 1'b0;
      nvm_erase <= 1'b0;
      nvm_rd_flash <= 1'b0;
      nvm_rd_ee <= 1'b0;
    end else begin
      nvm_pbuf_we <= 1'b0;
      nvm_page_we <= 1'b0;
      nvm_ee_we <= 1'b0;
      nvm_erase <= 1'b0;
      nvm_rd_flash <= 1'b0;
      nvm_rd_ee <= 1'b0;
      if (done24) begin
        if ((b1_24 & H_MASK) == OP_RD_FLASH) begin
          nvm_rd_flash <= 1'b1;
          nvm_addr <= next_sr[15:0];
          nvm_hi <= b1_24[H_BIT];
        end else if (b1_24 == OP_RD_EE) begin
          nvm_rd_ee <= 1'b1;
          nvm_addr <= {4'h0, next_sr[11:0]};
        end
      end else if (done32) begin
        if ((b1_32 & H_MASK) == OP_LD_PAGE) begin
          nvm_pbuf_we <= 1'b1;
          nvm_addr <= {9'h0, b3_32[6:0]};
          nvm_hi <= b1_32[H_BIT];
          nvm_wdata <= b4_32;
        end else if (b1_32 == OP_WR_PAGE && !busy) begin
          nvm_page_we <= 1'b1;
          nvm_addr <= {b2_32, b3_32[7], 7'h00};
        end else if (b1_32 == OP_WR_EE && !busy) begin
          nvm_ee_we <= 1'b1;
          nvm_addr <= {4'h0, b2_32[3:0], b3_32};
          nvm_wdata <= b4_32;
        end else if (b1_32 == OP_ENABLE_1 && b2_32[7:5] == OP_ERASE_2 && !busy) begin
          nvm_erase <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Read-back capture
  // ==========================================================
  logic rd_cap;        // Memory data valid this cycle
  logic rd_was_flash;  // Captured read targets Flash
  logic [7:0] rd_byte; // Byte four to send
  logic [7:0] rd_value; // Masked memory data
  logic blank;         // Location is being programmed

  assign blank = (pend == PEND_ERASE)
    | (rd_was_flash & (pend == PEND_FLASH) & (nvm_addr[15:7] == busy_addr[15:7]))
    | (~rd_was_flash & (pend == PEND_EEPROM) & (nvm_addr == busy_addr));
  assign rd_value = blank ? BLANK_BYTE : nvm_rd_data;

  // Choose what byte four carries
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_cap <= 1'b0;
      rd_was_flash <= 1'b0;
      rd_byte <= 8'h0;
    end else begin
      rd_cap <= nvm_rd_flash | nvm_rd_ee;
      rd_was_flash <= nvm_rd_flash;
      if (done24) begin
        rd_byte <= (b1_24 == OP_POLL) ? {7'h0, busy} : next_sr[7:0];
      end else if (rd_cap) begin
        rd_byte <= rd_value;
      end
    end
  end

  // ==========================================================
  // Transmit on the falling edge
  // ==========================================================
  logic [7:0] tx;       // Remaining output bits
  logic [7:0] tx_load;  // Byte started at a boundary

  assign tx_load = (enabled && cnt == CNT_BYTE4_FIRST) ? rd_byte : sr[7:0];

  // MSB first, previous byte echoed unless byte four carries data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      miso <= 1'b0;
      tx <= 8'h0;
    end else if (!isp_active) begin
      miso <= 1'b0;
    end else if (fall) begin
      if (cnt[2:0] == 3'h0) begin
        miso <= tx_load[7];
        tx <= {tx_load[6:0], 1'b0};
      end else begin
        miso <= tx[7];
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic rd_msb; // Top bit of byte four
  assign rd_msb = rd_byte[7];

  sequence s_rd_flash;
    done24 && ((b1_24 & H_MASK) == OP_RD_FLASH);
  endsequence
  sequence s_ld_page;
    done32 && ((b1_32 & H_MASK) == OP_LD_PAGE);
  endsequence

  a_sync_enable: assert property (rise && !enabled && next_sr[15:0] == 16'hac53 |=> enabled && cnt == 5'h10)
    else $error("enable word did not bring sync");
  a_unsync_quiet: assert property (!enabled ##1 !enabled |-> !(nvm_pbuf_we || nvm_page_we || nvm_ee_we || nvm_erase))
    else $error("strobe while out of sync");
  a_mosi_sample: assert property (rise |=> sr[0] == $past(mosi_s))
    else $error("MOSI not sampled on rise");
  a_miso_fall: assert property ($changed(miso) |-> $past(fall) || $past(!isp_active))
    else $error("MISO moved outside a falling edge");
  a_read_flow: assert property (s_rd_flash |=> nvm_rd_flash ##1 rd_cap ##1 rd_byte == $past(rd_value))
    else $error("Flash read data not captured");
  a_page_load: assert property (s_ld_page |=> nvm_pbuf_we && {1'b0, nvm_addr[6:0]} == ($past(b3_32) & 8'h7f))
    else $error("page load index wrong");
  a_page_busy: assert property (nvm_page_we && !busy |=> (pend == PEND_FLASH)[*8])
    else $error("page write did not start timing");
  a_flash_blank: assert property (rd_cap && rd_was_flash && pend == PEND_FLASH
    && nvm_addr[15:7] == busy_addr[15:7] |=> rd_byte == 8'hff)
    else $error("busy page did not read blank");
  a_ee_blank: assert property (rd_cap && !rd_was_flash && pend == PEND_EEPROM
    && nvm_addr == busy_addr |=> rd_byte == 8'hff)
    else $error("busy EEPROM byte did not read blank");
  a_ee_write: assert property (done32 && b1_32 == OP_WR_EE && !busy |=> nvm_ee_we && nvm_wdata == $past(b4_32))
    else $error("EEPROM write data wrong");
  a_erase_start: assert property (done32 && b1_32 == 8'hac && b2_32[7:5] == 3'h4 && !busy
    |=> nvm_erase ##1 pend == PEND_ERASE)
    else $error("erase did not start");
  a_poll_flag: assert property (done24 && b1_24 == OP_POLL |=> rd_byte == {7'h0, $past(busy)})
    else $error("poll byte wrong");
  a_bit_wrap: assert property (rise && enabled && cnt == 5'h1f |=> cnt == 5'h0)
    else $error("instruction length not 32");
  a_byte4_out: assert property (fall && enabled && cnt == 5'h18 |=> miso == $past(rd_msb))
    else $error("byte four not sent");

endmodule : isp_port

// >>> src/sync3.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes the input is asynchronous to clk; output follows once stages two and three agree.
*/
`timescale 1ns/1ps
module sync3 #(
  parameter logic INIT = 1'b0 // Value held during reset
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input
  input wire logic async_in,
  // Filtered level
  output logic stable
);

  logic [2:0] stage; // Shift stages, stage[0] first

  // Shift chain and agreement filter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage <= {3{INIT}};
      stable <= INIT;
    end else begin
      stage <= {stage[1:0], async_in};
      if (stage[1] == stage[2]) begin
        stable <= stage[2];
      end
    end
  end

endmodule : sync3
